// ---- upl_defs.svh ----
// Shared constants for the uplink nibble/byte role interface
// Operation
// (RULE1) Strap level picks nibble role, PHY or MAC
// (RULE2) PHY role: take transmit, drive receive, clocks, status
// (RULE3) MAC role: drive PHY inputs, take status, clocks
// (RULE4) Nibble mode moves one four-bit word per clock
// (RULE5) Transmit side carries valid and error with data
// (RULE6) Receive side carries valid and error with data
// (RULE7) Collision for half duplex, not at gigabit
// (RULE8) Far end ties its unused error input low
// (RULE9) Same strap picks the byte-wide role
// (RULE10) Byte PHY role: transmit clock is an input
// (RULE11) Byte MAC role: device drives receive clock out
// (RULE12) Byte mode moves eight bits per clock
// (RULE13) Gigabit byte mode is full duplex only
// (RULE14) Nibble clock 2.5 or 25 MHz
// (RULE15) Byte clock 125 MHz
// (RULE16) Carrier sense shows carrier, collision shows collision
// (RULE17) Strap caught during reset, role fixed until reset
`ifndef UPL_DEFS_SVH
`define UPL_DEFS_SVH
`define UPL_DATA_W        8
`define UPL_NIBBLE_MASK   8'h0f
`define UPL_BYTE_MASK     8'hff
`define UPL_STRAP_PHY     1'b1
`define UPL_MII10_KHZ     2500
`define UPL_MII100_KHZ    25000
`define UPL_GMII_KHZ      125000
`define UPL_SYS_KHZ       25000
`endif

// ---- upl_pkg.sv ----
// Types shared by both ends of the uplink interface
package upl_pkg;
  typedef enum logic [1:0]
  {
    UPL_ROLE_MAC = 2'b01,
    UPL_ROLE_PHY = 2'b10
  } upl_role_t;
endpackage : upl_pkg

// ---- upl_link_if.sv ----
// Pin bundle between the switch uplink and its external partner
`timescale 1ns/1ps
`include "upl_defs.svh"
interface upl_link_if
  (
  input wire logic link_clk
  );
  // Unidirectional pins, named from the switch side
  logic                   uplink_tx_enable_in;
  logic                   uplink_tx_error_in;
  logic [`UPL_DATA_W-1:0] uplink_tx_data_in;
  logic                   uplink_rx_valid_out;
  logic                   uplink_rx_error_out;
  logic [`UPL_DATA_W-1:0] uplink_rx_data_out;
  // Two-way pins; in byte mode the clock pins carry the gigabit clocks
  logic                   dev_tx_clock_out;
  logic                   dev_tx_clock_oe;
  logic                   par_tx_clock_out;
  logic                   par_tx_clock_oe;
  logic                   dev_rx_clock_out;
  logic                   dev_rx_clock_oe;
  logic                   par_rx_clock_out;
  logic                   par_rx_clock_oe;
  logic                   dev_collision_out;
  logic                   dev_collision_oe;
  logic                   par_collision_out;
  logic                   par_collision_oe;
  logic                   dev_carrier_out;
  logic                   dev_carrier_oe;
  logic                   par_carrier_out;
  logic                   par_carrier_oe;
  // Resolved wire levels
  logic                   uplink_tx_clock;
  logic                   uplink_rx_clock;
  logic                   uplink_collision;
  logic                   uplink_carrier_sense;
  assign uplink_tx_clock      = dev_tx_clock_oe ? dev_tx_clock_out :
                                (par_tx_clock_oe & par_tx_clock_out);
  assign uplink_rx_clock      = dev_rx_clock_oe ? dev_rx_clock_out :
                                (par_rx_clock_oe & par_rx_clock_out);
  assign uplink_collision     = dev_collision_oe ? dev_collision_out :
                                (par_collision_oe & par_collision_out);
  assign uplink_carrier_sense = dev_carrier_oe ? dev_carrier_out :
                                (par_carrier_oe & par_carrier_out);
  modport device
  (
    input  uplink_tx_enable_in, uplink_tx_error_in, uplink_tx_data_in,
    output uplink_rx_valid_out, uplink_rx_error_out, uplink_rx_data_out,
    output dev_tx_clock_out, dev_tx_clock_oe, dev_rx_clock_out, dev_rx_clock_oe,
    output dev_collision_out, dev_collision_oe, dev_carrier_out, dev_carrier_oe,
    input  uplink_tx_clock, uplink_rx_clock, uplink_collision, uplink_carrier_sense
  );
  modport partner
  (
    output uplink_tx_enable_in, uplink_tx_error_in, uplink_tx_data_in,
    input  uplink_rx_valid_out, uplink_rx_error_out, uplink_rx_data_out,
    output par_tx_clock_out, par_tx_clock_oe, par_rx_clock_out, par_rx_clock_oe,
    output par_collision_out, par_collision_oe, par_carrier_out, par_carrier_oe,
    input  uplink_tx_clock, uplink_rx_clock, uplink_collision, uplink_carrier_sense
  );
endinterface : upl_link_if

// ---- upl_partner.sv ----
// External MAC or PHY facing the switch uplink
`timescale 1ns/1ps
`include "upl_defs.svh"
module upl_partner
  import upl_pkg::*;
  (
  input  wire logic                   link_clk,
  input  wire logic                   link_rst,
  input  wire logic                   device_role_phy,
  input  wire logic                   byte_mode,
  input  wire logic                   full_duplex,
  upl_link_if.partner                 link,
  input  wire logic                   send_valid,
  input  wire logic                   send_error,
  input  wire logic [`UPL_DATA_W-1:0] send_data,
  output logic                        recv_valid,
  output logic [`UPL_DATA_W-1:0]      recv_data,
  output logic                        recv_error
  );
  logic                   drv_en;
  logic                   drv_err;
  logic [`UPL_DATA_W-1:0] drv_data;
  logic                   crs;
  logic                   col;
  logic                   rv;
  logic [`UPL_DATA_W-1:0] rd;
  logic                   next_drv_en;
  logic                   next_drv_err;
  logic [`UPL_DATA_W-1:0] next_drv_data;
  logic                   next_crs;
  logic                   next_col;
  logic                   next_rv;
  logic [`UPL_DATA_W-1:0] next_rd;
  logic [`UPL_DATA_W-1:0] mask;
  logic                   partner_rx_error;

  assign mask             = byte_mode ? `UPL_BYTE_MASK : `UPL_NIBBLE_MASK;
  assign partner_rx_error = 1'b0; // [RULE8]

  always_comb
  begin
    next_drv_en   = send_valid;                            // [RULE5]
    next_drv_err  = send_error;
    next_drv_data = send_data & mask;                      // [RULE4] [RULE12]
    next_rv       = link.uplink_rx_valid_out;              // [RULE6]
    next_rd       = link.uplink_rx_data_out & mask;
    next_crs      = send_valid | link.uplink_rx_valid_out; // [RULE16]
    next_col      = send_valid & link.uplink_rx_valid_out
                    & ~full_duplex & ~byte_mode;           // [RULE7] [RULE13]
    if (link_rst)
    begin
      next_drv_en   = 1'b0;
      next_drv_err  = 1'b0;
      next_drv_data = '0;
      next_rv       = 1'b0;
      next_rd       = '0;
      next_crs      = 1'b0;
      next_col      = 1'b0;
    end
  end

  always_ff @(posedge link_clk)
  begin
    drv_en   <= next_drv_en;
    drv_err  <= next_drv_err;
    drv_data <= next_drv_data;
    rv       <= next_rv;
    rd       <= next_rd;
    crs      <= next_crs;
    col      <= next_col;
  end

  assign link.uplink_tx_enable_in = drv_en;
  assign link.uplink_tx_error_in  = drv_err;
  assign link.uplink_tx_data_in   = drv_data;
  assign recv_valid               = rv;
  assign recv_data                = rd;
  assign recv_error               = partner_rx_error;
  // Partner owns status and clocks the switch does not drive
  assign link.par_carrier_out   = crs;
  assign link.par_carrier_oe    = ~device_role_phy & ~link_rst;             // [RULE3]
  assign link.par_collision_out = col;
  assign link.par_collision_oe  = ~device_role_phy & ~link_rst;             // [RULE3]
  assign link.par_tx_clock_out  = link_clk;
  assign link.par_tx_clock_oe   = (~device_role_phy | byte_mode) & ~link_rst; // [RULE10]
  assign link.par_rx_clock_out  = link_clk;
  assign link.par_rx_clock_oe   = ~device_role_phy & ~byte_mode & ~link_rst; // [RULE11]
endmodule : upl_partner

// ---- upl_device.sv ----
// Switch uplink end: role strap, pin directions and domain crossings
`timescale 1ns/1ps
`include "upl_defs.svh"
module upl_device
  import upl_pkg::*;
  (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   link_clk,
  input  wire logic                   role_select_strap,
  input  wire logic                   byte_mode,
  input  wire logic                   full_duplex,
  upl_link_if.device                  link,
  input  wire logic                   send_valid,
  output logic                        send_ready,
  input  wire logic                   send_error,
  input  wire logic [`UPL_DATA_W-1:0] send_data,
  output logic                        recv_valid,
  output logic                        recv_error,
  output logic [`UPL_DATA_W-1:0]      recv_data,
  output logic                        role_is_phy,
  output logic                        carrier_seen,
  output logic                        collision_seen
  );
  // System domain state
  upl_role_t              role;
  upl_role_t              next_role;
  logic                   strap_s1;
  logic                   strap_s2;
  logic                   req_tog;
  logic                   next_req_tog;
  logic                   tx_err;
  logic                   next_tx_err;
  logic [`UPL_DATA_W-1:0] tx_data;
  logic [`UPL_DATA_W-1:0] next_tx_data;
  logic                   ack_c1;
  logic                   ack_c2;
  logic                   cap_c1;
  logic                   cap_c2;
  logic                   cap_c3;
  logic                   rv;
  logic                   next_rv;
  logic                   re;
  logic                   next_re;
  logic [`UPL_DATA_W-1:0] rd;
  logic [`UPL_DATA_W-1:0] next_rd;
  logic [1:0]             st_c1;
  logic [1:0]             st_c2;
  // Link domain state
  logic                   rst_l1;
  logic                   rst_l2;
  logic [2:0]             cfg_l1;
  logic [2:0]             cfg_l2;
  logic                   req_l1;
  logic                   req_l2;
  logic                   ack_l;
  logic                   next_ack_l;
  logic                   out_v;
  logic                   next_out_v;
  logic                   out_e;
  logic                   next_out_e;
  logic [`UPL_DATA_W-1:0] out_d;
  logic [`UPL_DATA_W-1:0] next_out_d;
  logic                   cap_tog;
  logic                   next_cap_tog;
  logic                   cap_e;
  logic                   next_cap_e;
  logic [`UPL_DATA_W-1:0] cap_d;
  logic [`UPL_DATA_W-1:0] next_cap_d;
  logic                   crs;
  logic                   next_crs;
  logic                   col;
  logic                   next_col;
  logic                   phy_l;
  logic                   byte_l;
  logic                   fd_l;
  logic [`UPL_DATA_W-1:0] mask_l;

  function automatic logic [`UPL_DATA_W-1:0] lane_mask(input logic wide);
    lane_mask = wide ? `UPL_BYTE_MASK : `UPL_NIBBLE_MASK;
  endfunction : lane_mask

  // Strap synchroniser and role capture
  always_comb
  begin
    next_role = role;
    if (sys_rst)
    begin
      next_role = (strap_s2 == `UPL_STRAP_PHY) ? UPL_ROLE_PHY : UPL_ROLE_MAC; // [RULE1] [RULE9]
    end
  end

  always_ff @(posedge clk)
  begin
    strap_s1 <= role_select_strap;
    strap_s2 <= strap_s1;
    role     <= next_role; // [RULE17]
  end

  // User to link word handshake, one word in flight
  assign send_ready = (req_tog == ack_c2) & ~sys_rst;

  always_comb
  begin
    next_req_tog = req_tog;
    next_tx_err  = tx_err;
    next_tx_data = tx_data;
    if (sys_rst)
    begin
      next_req_tog = 1'b0;
      next_tx_err  = 1'b0;
      next_tx_data = '0;
    end
    else if (send_valid && send_ready)
    begin
      next_req_tog = ~req_tog;
      next_tx_err  = send_error;
      next_tx_data = send_data;
    end
  end

  always_ff @(posedge clk)
  begin
    req_tog <= next_req_tog;
    tx_err  <= next_tx_err;
    tx_data <= next_tx_data;
    ack_c1  <= ack_l;
    ack_c2  <= ack_c1;
  end

  // Link to user word delivery
  always_comb
  begin
    next_rv = 1'b0;
    next_re = re;
    next_rd = rd;
    if (sys_rst)
    begin
      next_re = 1'b0;
      next_rd = '0;
    end
    else if (cap_c2 != cap_c3)
    begin
      next_rv = 1'b1;
      next_re = cap_e; // [RULE5]
      next_rd = cap_d;
    end
  end

  always_ff @(posedge clk)
  begin
    cap_c1 <= cap_tog;
    cap_c2 <= cap_c1;
    cap_c3 <= sys_rst ? 1'b0 : cap_c2;
    rv     <= next_rv;
    re     <= next_re;
    rd     <= next_rd;
    st_c1  <= {crs, col};
    st_c2  <= st_c1;
  end

  assign recv_valid     = rv;
  assign recv_error     = re;
  assign recv_data      = rd;
  assign role_is_phy    = (role == UPL_ROLE_PHY);
  assign carrier_seen   = st_c2[1];
  assign collision_seen = st_c2[0];

  // Link domain: reset and configuration synchronisers
  always_ff @(posedge link_clk)
  begin
    rst_l1 <= sys_rst;
    rst_l2 <= rst_l1;
    cfg_l1 <= {role == UPL_ROLE_PHY, byte_mode, full_duplex};
    cfg_l2 <= cfg_l1;
    req_l1 <= req_tog;
    req_l2 <= req_l1;
  end

  assign phy_l  = cfg_l2[2];
  assign byte_l = cfg_l2[1];
  assign fd_l   = cfg_l2[0];
  assign mask_l = lane_mask(byte_l);

  always_comb
  begin
    next_ack_l   = ack_l;
    next_out_v   = 1'b0;
    next_out_e   = 1'b0;
    next_out_d   = '0;
    next_cap_tog = cap_tog;
    next_cap_e   = cap_e;
    next_cap_d   = cap_d;
    next_crs     = 1'b0;
    next_col     = 1'b0;
    if (rst_l2)
    begin
      next_ack_l   = 1'b0;
      next_cap_tog = 1'b0;
      next_cap_e   = 1'b0;
      next_cap_d   = '0;
    end
    else
    begin
      // Switch receive lines: valid, error and one word per clock
      if (req_l2 != ack_l)
      begin
        next_ack_l = req_l2;
        next_out_v = 1'b1;              // [RULE6]
        next_out_e = tx_err;
        next_out_d = tx_data & mask_l;  // [RULE4] [RULE12]
      end
      // Switch transmit-side lines sampled each link clock
      if (link.uplink_tx_enable_in || link.uplink_tx_error_in)
      begin
        next_cap_tog = ~cap_tog;
        next_cap_e   = link.uplink_tx_error_in;                    // [RULE5]
        next_cap_d   = link.uplink_tx_data_in & mask_l;            // [RULE2] [RULE3]
      end
      if (phy_l)
      begin
        next_crs = out_v | link.uplink_tx_enable_in;               // [RULE16]
        next_col = out_v & link.uplink_tx_enable_in & ~fd_l & ~byte_l; // [RULE7] [RULE13]
      end
      else
      begin
        next_crs = link.uplink_carrier_sense;                      // [RULE3]
        next_col = link.uplink_collision & ~byte_l;                // [RULE13]
      end
    end
  end

  always_ff @(posedge link_clk)
  begin
    ack_l   <= next_ack_l;
    out_v   <= next_out_v;
    out_e   <= next_out_e;
    out_d   <= next_out_d;
    cap_tog <= next_cap_tog;
    cap_e   <= next_cap_e;
    cap_d   <= next_cap_d;
    crs     <= next_crs;
    col     <= next_col;
  end

  assign link.uplink_rx_valid_out = out_v;
  assign link.uplink_rx_error_out = out_e;
  assign link.uplink_rx_data_out  = out_d;
  // Pin directions follow the captured role
  assign link.dev_carrier_out   = crs;
  assign link.dev_carrier_oe    = phy_l & ~rst_l2;                       // [RULE2]
  assign link.dev_collision_out = col;
  assign link.dev_collision_oe  = phy_l & ~rst_l2;                       // [RULE2]
  assign link.dev_tx_clock_out  = link_clk;                              // [RULE14]
  assign link.dev_tx_clock_oe   = phy_l & ~byte_l & ~rst_l2;             // [RULE10]
  assign link.dev_rx_clock_out  = link_clk;                              // [RULE15]
  assign link.dev_rx_clock_oe   = (phy_l | byte_l) & ~rst_l2;            // [RULE11]
endmodule : upl_device

// ---- upl_link_assertions.sv ----
// Link-side checker for the uplink role interface
`timescale 1ns/1ps
`include "upl_defs.svh"
module upl_link_checker
  (
  input wire logic                   link_clk,
  input wire logic                   link_rst,
  input wire logic                   device_role_phy,
  input wire logic                   byte_mode,
  input wire logic                   full_duplex,
  input wire logic                   uplink_tx_enable_in,
  input wire logic                   uplink_rx_valid_out,
  input wire logic [`UPL_DATA_W-1:0] uplink_rx_data_out,
  input wire logic                   dev_tx_clock_oe,
  input wire logic                   dev_rx_clock_oe,
  input wire logic                   par_tx_clock_oe,
  input wire logic                   par_rx_clock_oe,
  input wire logic                   dev_collision_oe,
  input wire logic                   dev_carrier_oe,
  input wire logic                   uplink_collision,
  input wire logic                   uplink_carrier_sense
  );
  logic [3:0] settle;
  logic [3:0] next_settle;
  logic       ok;
  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (link_rst);
  // Pin directions settle a few link clocks after reset
  always_comb
  begin
    next_settle = settle;
    if (link_rst)
      next_settle = 4'h0;
    else if (settle != 4'hf)
      next_settle = settle + 4'h1;
  end
  always_ff @(posedge link_clk)
    settle <= next_settle;
  assign ok = (settle > 4'h7);
  property p_phy_nib;
    ok && device_role_phy && !byte_mode |-> dev_tx_clock_oe && dev_rx_clock_oe
      && dev_collision_oe && dev_carrier_oe && !par_tx_clock_oe;
  endproperty
  a_phy_nib: assert property (p_phy_nib) else $error("phy nibble pins wrong");
  property p_mac_nib;
    ok && !device_role_phy && !byte_mode |-> !dev_tx_clock_oe && !dev_rx_clock_oe
      && !dev_collision_oe && !dev_carrier_oe && par_tx_clock_oe && par_rx_clock_oe;
  endproperty
  a_mac_nib: assert property (p_mac_nib) else $error("mac nibble pins wrong");
  property p_phy_byte;
    ok && device_role_phy && byte_mode |-> !dev_tx_clock_oe && dev_rx_clock_oe
      && dev_carrier_oe && par_tx_clock_oe;
  endproperty
  a_phy_byte: assert property (p_phy_byte) else $error("phy byte pins wrong");
  property p_mac_byte;
    ok && !device_role_phy && byte_mode |-> dev_rx_clock_oe && !dev_tx_clock_oe
      && !dev_carrier_oe && !dev_collision_oe && par_tx_clock_oe && !par_rx_clock_oe;
  endproperty
  a_mac_byte: assert property (p_mac_byte) else $error("mac byte pins wrong");
  property p_rx_one;
    $rose(uplink_rx_valid_out) |=> !uplink_rx_valid_out;
  endproperty
  a_rx_one: assert property (p_rx_one) else $error("rx valid too long");
  property p_nib_mask;
    ok && !byte_mode && uplink_rx_valid_out |-> uplink_rx_data_out[7:4] == 4'h0;
  endproperty
  a_nib_mask: assert property (p_nib_mask) else $error("upper nibble set");
  property p_carrier;
    ok && device_role_phy |->
      uplink_carrier_sense == $past(uplink_rx_valid_out | uplink_tx_enable_in);
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier wrong");
  property p_col_half;
    ok && device_role_phy && !byte_mode && !full_duplex |->
      uplink_collision == $past(uplink_rx_valid_out & uplink_tx_enable_in);
  endproperty
  a_col_half: assert property (p_col_half) else $error("collision wrong");
  property p_col_none;
    ok && (byte_mode || full_duplex) |-> !uplink_collision;
  endproperty
  a_col_none: assert property (p_col_none) else $error("collision in full duplex");
endmodule : upl_link_checker

// ---- tb.sv ----
// Testbench joining both uplink ends and checking traffic both ways
`timescale 1ns/1ps
`include "upl_defs.svh"
module tb;
  logic       clk = 0, link_clk = 0, sys_rst = 1, link_rst = 1;
  logic       strap = 1, byte_mode = 0, full_duplex = 0, role = 1;
  logic       d_sv = 0, d_se = 0, d_sr, d_rv, d_re, is_phy, car_seen, col_seen;
  logic       p_sv = 0, p_se = 0, p_rv, p_re, err_q = 0, col_hit = 0;
  logic [7:0] d_sd = 0, d_rd, p_sd = 0, p_rd;
  logic [8:0] exp_dev[$], exp_par[$];
  int         errors = 0, checks = 0, cycles = 0;
  localparam logic [2:0] CFG [5] = '{3'b100, 3'b000, 3'b101, 3'b111, 3'b011};
  always #20 clk = ~clk;
  initial
  begin
    #13;
    forever #80 link_clk = ~link_clk;
  end
  upl_link_if i_upl_link_if (.link_clk(link_clk));
  upl_device i_upl_device (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .role_select_strap(strap), .byte_mode(byte_mode), .full_duplex(full_duplex),
    .link(i_upl_link_if.device), .send_valid(d_sv), .send_ready(d_sr), .send_error(d_se),
    .send_data(d_sd), .recv_valid(d_rv), .recv_error(d_re), .recv_data(d_rd),
    .role_is_phy(is_phy), .carrier_seen(car_seen), .collision_seen(col_seen));
  upl_partner i_upl_partner (.link_clk(link_clk), .link_rst(link_rst),
    .device_role_phy(role), .byte_mode(byte_mode), .full_duplex(full_duplex),
    .link(i_upl_link_if.partner), .send_valid(p_sv), .send_error(p_se), .send_data(p_sd),
    .recv_valid(p_rv), .recv_data(p_rd), .recv_error(p_re));
  upl_link_checker i_upl_link_checker (.link_clk(link_clk), .link_rst(link_rst),
    .device_role_phy(role), .byte_mode(byte_mode), .full_duplex(full_duplex),
    .uplink_tx_enable_in(i_upl_link_if.uplink_tx_enable_in),
    .uplink_rx_valid_out(i_upl_link_if.uplink_rx_valid_out),
    .uplink_rx_data_out(i_upl_link_if.uplink_rx_data_out),
    .dev_tx_clock_oe(i_upl_link_if.dev_tx_clock_oe),
    .dev_rx_clock_oe(i_upl_link_if.dev_rx_clock_oe),
    .par_tx_clock_oe(i_upl_link_if.par_tx_clock_oe),
    .par_rx_clock_oe(i_upl_link_if.par_rx_clock_oe),
    .dev_collision_oe(i_upl_link_if.dev_collision_oe),
    .dev_carrier_oe(i_upl_link_if.dev_carrier_oe),
    .uplink_collision(i_upl_link_if.uplink_collision),
    .uplink_carrier_sense(i_upl_link_if.uplink_carrier_sense));
  task automatic report_and_stop();
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic cmp_word(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({8'h00, got}, {8'h00, exp});
  endtask : cmp_bit
  function automatic logic [7:0] lane_mask(input logic [7:0] d);
    return d & (byte_mode ? `UPL_BYTE_MASK : `UPL_NIBBLE_MASK);
  endfunction : lane_mask
  // Words reaching the device user side, and timeout
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      report_and_stop();
    end
    if (sys_rst)
      col_hit = 1'b0;
    else if (col_seen === 1'b1)
      col_hit = 1'b1;
    if (d_rv === 1'b1)
      cmp_word({d_re, d_rd}, exp_dev.size() ? exp_dev.pop_front() : 'x);
  end
  // Words reaching the partner user side, error flag taken from the pin a cycle earlier
  always @(posedge link_clk)
  begin
    if (p_rv === 1'b1)
    begin
      cmp_word({err_q, p_rd}, exp_par.size() ? exp_par.pop_front() : 'x);
      cmp_bit(p_re, 1'b0);
    end
    err_q = i_upl_link_if.uplink_rx_error_out;
  end
  task automatic do_reset(input logic [2:0] c);
    @(posedge clk);
    #2 {role, byte_mode, full_duplex} = c;
    strap = c[2];
    sys_rst = 1;
    link_rst = 1;
    repeat (6) @(posedge link_clk);
    #2 link_rst = 0;
    @(posedge clk);
    #2 sys_rst = 0;
    strap = ~c[2];
    repeat (8) @(posedge link_clk);
  endtask : do_reset
  task automatic dev_send(input logic [7:0] d, input logic e);
    int n = 0;
    @(posedge clk);
    #2;
    while (d_sr !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      #2 n++;
    end
    d_sv = 1;
    d_sd = d;
    d_se = e;
    exp_par.push_back({e, lane_mask(d)});
    @(posedge clk);
    #2 d_sv = 0;
  endtask : dev_send
  task automatic par_burst(input int n, input int ep);
    logic [7:0] d;
    for (int i = 0; i < n; i++)
    begin
      @(posedge link_clk);
      d = 8'($urandom);
      #2 p_sv = (i != ep);
      p_se = (i == ep);
      p_sd = d;
      exp_dev.push_back({i == ep, lane_mask(d)});
    end
    @(posedge link_clk);
    #2 p_sv = 0;
    p_se = 0;
  endtask : par_burst
  initial
  begin
    int n;
    void'($urandom(32'h20a7));
    for (int k = 0; k < 5; k++)
    begin
      do_reset(CFG[k]);
      cmp_bit(is_phy, CFG[k][2]);
      repeat (3) dev_send(8'($urandom), 1'($urandom));
      par_burst(4, 2);
      fork
        par_burst(8, 9);
        repeat (2) dev_send(8'($urandom), 1'b0);
        begin
          repeat (5) @(posedge link_clk);
          #2 cmp_bit(car_seen, 1'b1);
        end
      join
      n = 0;
      while ((exp_dev.size() != 0 || exp_par.size() != 0) && n < 400)
      begin
        @(posedge clk);
        n++;
      end
      cmp_bit(n < 400, 1'b1);
      repeat (4) @(posedge link_clk);
      #2 cmp_bit(car_seen, 1'b0);
      cmp_bit(col_hit, ~CFG[k][1] & ~CFG[k][0]);
    end
    report_and_stop();
  end
endmodule : tb
